//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clock, rstn, regStore, selCs1, selCs2, selCs3, loByte, registerSelect;
  logic        generalClear, missedTransferError, slow, endOfSegmentFlag, memoryDone, nonexistentDevice;
  logic [15:0] hostData, cs1ReadData, cs2ReadData, cs3ReadData;
  logic        startInitPulse, busy, ready, readCmd, writeCmd, writeCheckCmd, reverseDir;
  logic        functionLoadFlag, parityTestBit, addressIncrementInhibit, programClear;
  logic [2:0]  driveSelectLines;
  logic [3:0]  invertByteParityCheck, parityInvert;
  int          fails = 0;
  int          samplesChecked = 0;

  tcc_control u_tcc_control (
    .clock                   (clock),
    .rstn                    (rstn),
    .regStore                (regStore),
    .selCs1                  (selCs1),
    .selCs2                  (selCs2),
    .selCs3                  (selCs3),
    .loByte                  (loByte),
    .hostData                (hostData),
    .registerSelect          (registerSelect),
    .generalClear            (generalClear),
    .endOfSegmentFlag        (endOfSegmentFlag),
    .memoryDone              (memoryDone),
    .missedTransferError     (missedTransferError),
    .nonexistentDevice       (nonexistentDevice),
    .startInitPulse          (startInitPulse),
    .busy                    (busy),
    .ready                   (ready),
    .readCmd                 (readCmd),
    .writeCmd                (writeCmd),
    .writeCheckCmd           (writeCheckCmd),
    .reverseDir              (reverseDir),
    .functionLoadFlag        (functionLoadFlag),
    .driveSelectLines        (driveSelectLines),
    .parityTestBit           (parityTestBit),
    .addressIncrementInhibit (addressIncrementInhibit),
    .programClear            (programClear),
    .invertByteParityCheck   (invertByteParityCheck),
    .parityInvert            (parityInvert),
    .cs1ReadData             (cs1ReadData),
    .cs2ReadData             (cs2ReadData),
    .cs3ReadData             (cs3ReadData)
  );
  tcc_drive_model u_tcc_drive_model (
    .clock             (clock),
    .busy              (busy),
    .slow              (slow),
    .driveSelectLines  (driveSelectLines),
    .endOfSegmentFlag  (endOfSegmentFlag),
    .memoryDone        (memoryDone),
    .nonexistentDevice (nonexistentDevice)
  );

  // Free-running controller clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic tick(input int n);
    // Release a strobe left up by the last store before any further edge
    if (regStore) regStore = 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Low-byte store to control word w (1..3); the strobe stays up until the next
  // tick, so back-to-back stores never drop and raise it in one time step
  task automatic store(input logic [2:0] w, input logic [15:0] d);
    {selCs3, selCs2, selCs1} = 3'h1 << (w - 3'h1);
    hostData = d;
    regStore = 1'b1;
    @(posedge clock);
    #1;
  endtask : store

  // Drop the register selection for one cycle so command flops may clear
  task automatic idle;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) tick(1);
    chk(busy, 1'b0);
    registerSelect = 1'b0;
    tick(1);
    chk({ready, readCmd, writeCmd, writeCheckCmd, functionLoadFlag}, 5'h10);
    registerSelect = 1'b1;
  endtask : idle

  task automatic t_codes;
    logic [15:0] codes [8] = '{16'h0029, 16'h002B, 16'h002D, 16'h002F, 16'h0031, 16'h0037, 16'h0039, 16'h003F};
    logic [2:0]  m;
    foreach (codes[i]) begin
      m = codes[i][5:3];
      store(3'h1, codes[i]);
      chk(startInitPulse, 1'b1);
      chk(busy, 1'b1);
      chk({readCmd, writeCmd, writeCheckCmd}, {m == 3'h7, m == 3'h6, m == 3'h5});
      chk(reverseDir, codes[i][2:0] == 3'h7);
      chk({ready, cs1ReadData}, {1'b0, 16'h0800});
      tick(1);
      chk({startInitPulse, functionLoadFlag}, 2'h1);
      for (int k = 0; k < 40 && busy !== 1'b0; k++) tick(1);
      chk(functionLoadFlag, 1'b1);
      idle();
    end
  endtask : t_codes

  task automatic t_refuse;
    loByte = 1'b0;
    store(3'h1, 16'h0039);
    chk({startInitPulse, busy}, 2'h0);
    loByte = 1'b1;
    registerSelect = 1'b0;
    store(3'h1, 16'h0039);
    chk({startInitPulse, busy}, 2'h0);
    registerSelect = 1'b1;
    store(3'h1, 16'h0038);
    chk(startInitPulse, 1'b0);
    store(3'h1, 16'h0021);
    chk({startInitPulse, busy}, 2'h0);
    store(3'h1, 16'h0039);
    tick(1);
    store(3'h1, 16'h0031);
    chk({startInitPulse, readCmd, writeCmd, busy}, 4'h5);
    missedTransferError = 1'b1;
    tick(1);
    missedTransferError = 1'b0;
    chk(busy, 1'b0);
    idle();
    store(3'h1, 16'h0039);
    generalClear = 1'b1;
    tick(1);
    generalClear = 1'b0;
    chk(busy, 1'b0);
    idle();
    store(3'h2, 16'h0007);
    store(3'h1, 16'h0039);
    tick(2);
    chk(busy, 1'b0);
    idle();
  endtask : t_refuse

  task automatic t_cs2;
    store(3'h2, 16'h001D);
    chk(driveSelectLines, 3'h5);
    chk({parityTestBit, addressIncrementInhibit, programClear}, 3'h6);
    chk(cs2ReadData, 16'h001D);
    store(3'h1, 16'h0039);
    store(3'h2, 16'h0002);
    chk({driveSelectLines, addressIncrementInhibit, parityTestBit}, 5'h0A);
    store(3'h2, 16'h0020);
    chk({programClear, busy, addressIncrementInhibit}, 3'h4);
    tick(1);
    chk(programClear, 1'b0);
    idle();
  endtask : t_cs2

  task automatic t_cs3;
    store(3'h3, 16'h000A);
    chk({invertByteParityCheck, cs3ReadData}, {4'hA, 16'h000A});
    tick(1);
    chk(parityInvert, 4'hA);
    store(3'h1, 16'h0039);
    tick(1);
    chk(parityInvert, 4'h0);
    idle();
    store(3'h1, 16'h0031);
    tick(1);
    chk(parityInvert, 4'hA);
    idle();
  endtask : t_cs3

  task automatic summarize;
    if (fails == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // Main sequence: reset, then each scenario in turn
  initial begin
    {rstn, regStore, selCs1, selCs2, selCs3, generalClear, missedTransferError, slow} = 8'h00;
    {loByte, registerSelect} = 2'h3;
    hostData = 16'h0000;
    tick(2);
    rstn = 1'b1;
    chk({busy, ready, cs1ReadData}, {2'h1, 16'h0080});
    t_codes();
    slow = 1'b1;
    t_refuse();
    t_cs2();
    t_cs3();
    summarize();
  end

  // Hang guard, far beyond the roughly 120 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire

//--- bench/tcc_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_drive_model #(
  parameter logic [2:0] ABSENT_UNIT = 3'h7
) (
  input  wire logic       clock,
  input  wire logic       busy,
  input  wire logic       slow,
  input  wire logic [2:0] driveSelectLines,
  output logic            endOfSegmentFlag,
  output logic            memoryDone,
  output logic            nonexistentDevice
);
  logic [4:0] count;
  // Transfer length counter, restarts whenever the controller goes idle
  always_ff @(posedge clock) begin
    count <= busy ? count + 5'h01 : 5'h00;
  end
  // Drive ends the segment first, memory side finishes a little later
  assign endOfSegmentFlag = busy && (count >= (slow ? 5'h0C : 5'h03));
  assign memoryDone = busy && (count >= (slow ? 5'h0E : 5'h04));
  // One unit is never fitted, so it never answers
  assign nonexistentDevice = (driveSelectLines == ABSENT_UNIT);
endmodule : tcc_drive_model
`default_nettype wire

//--- rtl/tcc_control.sv
// How it works
// RULE_01: Software sets start bit; transfer codes odd.
// RULE_02: Codes 51-57 write-check; low digit 7 reverses.
// RULE_03: Start needs code, bit zero, low store.
// RULE_04: Ready start emits one initialize pulse.
// RULE_05: Initialize pulse sets busy.
// RULE_06: Function-load sets after initialize pulse.
// RULE_07: Function-load holds while selected, else clears.
// RULE_08: Ready when all command flops clear.
// RULE_09: Segment end plus memory done clears busy.
// RULE_10: Not busy clears the command flops; code clears them only when also deselected, or on a general or program clear.
// RULE_11: General clear forces busy clear.
// RULE_12: Missed transfer error forces busy clear.
// RULE_13: Function-load with missing drive clears busy.
// RULE_14: Four readable per-byte parity inversion bits.
// RULE_15: Inversion suppressed while reading.
// RULE_16: Inversion also applies in buffer maintenance.
// RULE_17: Unit select drives the drive-select lines.
// RULE_18: Second word low store loads unit, parity-test.
// RULE_19: Bit five in that store raises program clear.
// RULE_20: Parity test turns odd parity even.
// RULE_21: Parity test makes control parity even.
// RULE_22: Increment inhibit loads only ready; clear resets.
// RULE_23: Upper digit 5,6,7 decode check, write, read.
// RULE_24: Start while active is ignored entirely.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_params.svh"

module tcc_control (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        regStore,
  input  wire logic        selCs1,
  input  wire logic        selCs2,
  input  wire logic        selCs3,
  input  wire logic        loByte,
  input  wire logic [15:0] hostData,
  input  wire logic        registerSelect,
  input  wire logic        generalClear,
  input  wire logic        endOfSegmentFlag,
  input  wire logic        memoryDone,
  input  wire logic        missedTransferError,
  input  wire logic        nonexistentDevice,
  output logic             startInitPulse,
  output logic             busy,
  output logic             ready,
  output logic             readCmd,
  output logic             writeCmd,
  output logic             writeCheckCmd,
  output logic             reverseDir,
  output logic             functionLoadFlag,
  output logic [2:0]       driveSelectLines,
  output logic             parityTestBit,
  output logic             addressIncrementInhibit,
  output logic             programClear,
  output logic [3:0]       invertByteParityCheck,
  output logic [3:0]       parityInvert,
  output logic [15:0]      cs1ReadData,
  output logic [15:0]      cs2ReadData,
  output logic [15:0]      cs3ReadData
);

  // Upper octal digit to one-hot {read, write, writeCheck}
  // Digits 0-4 are not transfers and decode to zero, so they can never start
  function automatic logic [2:0] tcc_decode(input logic [2:0] digit);
    logic [2:0] hot;
    hot = 3'h0;
    case (digit)
      `TCC_CODE_READ:  hot = 3'h4;
      `TCC_CODE_WRITE: hot = 3'h2;
      `TCC_CODE_WCHK:  hot = 3'h1;
      default:         hot = 3'h0;
    endcase
    return hot;
  endfunction : tcc_decode

  // Reset image; ready is the only status bit up in the first word
  localparam tcc_pkg::tcc_state_s RESET_ST = '{
    phase:   tcc_pkg::PH_IDLE,
    busy:    1'b0,
    initPulse: 1'b0,
    cmd:     3'h0,
    reverse: 1'b0,
    ready:   1'b1,
    fnLoad:  1'b0,
    unitSel: `TCC_RST_UNIT,
    parTest: 1'b0,
    address_increment_inhibit:     1'b0,
    pgClr:   1'b0,
    invert_byte_parity_check:    `TCC_RST_INVERT_BYTE_PARITY_CHECK,
    inv:     `TCC_RST_INVERT_BYTE_PARITY_CHECK,
    cs1Rd:   `TCC_RST_CS1,
    cs2Rd:   `TCC_RST_WORD,
    cs3Rd:   `TCC_RST_WORD
  };

  tcc_pkg::tcc_state_s state;
  tcc_pkg::tcc_state_s next_state;

  // Store strobes, each qualified by the register selection
  // A store seen while deselected belongs to another unit and is dropped
  logic       storeCs1Lo;
  logic       storeCs2Lo;
  logic       storeCs3Lo;
  logic [2:0] codeHot;
  logic       goRequest;
  logic       accept;
  logic       pgWrite;
  logic       clearAll;
  logic       killBusy;

  always_comb begin
    storeCs1Lo = regStore && registerSelect && selCs1 && loByte;
    storeCs2Lo = regStore && registerSelect && selCs2 && loByte;
    storeCs3Lo = regStore && registerSelect && selCs3 && loByte;
    // RULE_23: upper digit decode
    codeHot    = tcc_decode(hostData[`TCC_MSD_MSB:`TCC_MSD_LSB]);
    // RULE_03: code, start bit and store coincide
    goRequest  = storeCs1Lo && (codeHot != 3'h0) && hostData[`TCC_GO_BIT];
    // RULE_19: program clear from bit five
    pgWrite    = storeCs2Lo && hostData[`TCC_PGCLR_BIT];
    clearAll   = generalClear || pgWrite;
    // RULE_11: general clear, RULE_12: missed transfer, RULE_13: missing drive
    killBusy   = clearAll || missedTransferError || (state.fnLoad && nonexistentDevice);
    // Aborts veto a start in the same cycle; a dead unit still goes busy until function-load catches it
    // RULE_04: only accepted in ready state
    // RULE_24: ignored while a command is active
    accept     = goRequest && state.ready && !killBusy;
  end

  // Next-state logic; clears are evaluated after sets so they win
  always_comb begin
    next_state = state;
    next_state.initPulse = 1'b0;
    next_state.pgClr     = pgWrite;

    // RULE_04: initialize pulse on accepted start
    // RULE_05: pulse sets busy
    if (accept) begin
      next_state.phase     = tcc_pkg::PH_INIT;
      next_state.initPulse = 1'b1;
      next_state.busy      = 1'b1;
      next_state.cmd       = codeHot;
      // RULE_02: low digit 7 selects reverse
      next_state.reverse   = (hostData[`TCC_LSD_MSB:`TCC_LSD_LSB] == `TCC_CODE_REVERSE);
    end else begin
      case (state.phase)
        tcc_pkg::PH_IDLE: next_state.phase = tcc_pkg::PH_IDLE;
        tcc_pkg::PH_INIT: next_state.phase = tcc_pkg::PH_RUN;
        tcc_pkg::PH_RUN: begin
          // RULE_09: normal completion
          if (endOfSegmentFlag && memoryDone) begin
            next_state.busy  = 1'b0;
            next_state.phase = tcc_pkg::PH_IDLE;
          end
        end
        default: next_state.phase = tcc_pkg::PH_IDLE;
      endcase
    end

    // RULE_11: forced clear
    // RULE_12: error abort
    // RULE_13: missing drive abort
    if (killBusy) begin
      next_state.busy  = 1'b0;
      next_state.phase = tcc_pkg::PH_IDLE;
    end

    // RULE_10: idle and deselected releases the command
    // Held while selected, so ready stays low in the first readback word until deselect
    if (!state.busy && !state.initPulse && !registerSelect) begin
      next_state.cmd     = 3'h0;
      next_state.reverse = 1'b0;
    end
    if (clearAll) begin
      next_state.cmd     = 3'h0;
      next_state.reverse = 1'b0;
    end

    // RULE_06: set after the pulse ends
    // RULE_07: held only while selected
    // This window is when a missing drive gets caught
    next_state.fnLoad = (state.initPulse || state.fnLoad) && registerSelect;

    // RULE_08: ready mirrors the command flops
    next_state.ready = (next_state.cmd == 3'h0);

    // RULE_18: unit select and parity test load
    if (storeCs2Lo) begin
      next_state.unitSel = hostData[`TCC_UNIT_MSB:`TCC_UNIT_LSB];
      next_state.parTest = hostData[`TCC_PAT_BIT];
    end

    // RULE_22: stores change inhibit only in ready, so no address spike mid-transfer
    if (storeCs2Lo && state.ready) begin
      next_state.address_increment_inhibit = hostData[`TCC_BAI_BIT];
    end
    if (clearAll) begin
      next_state.address_increment_inhibit = 1'b0;
    end

    // RULE_14: per-byte inversion bits
    if (storeCs3Lo) begin
      next_state.invert_byte_parity_check = hostData[`TCC_INVERT_BYTE_PARITY_CHECK_MSB:`TCC_INVERT_BYTE_PARITY_CHECK_LSB];
    end

    // RULE_15: suppressed during reads toward memory
    // RULE_16: same signals steer buffer maintenance parity
    next_state.inv = next_state.invert_byte_parity_check & {4{~next_state.cmd[2]}};

    // Readback words
    // Built from next values so readback and pins always agree
    next_state.cs1Rd = 16'h0000;
    next_state.cs1Rd[`TCC_CS1_READY_BIT] = next_state.ready;
    next_state.cs1Rd[`TCC_CS1_BUSY_BIT]  = next_state.busy;
    next_state.cs2Rd = 16'h0000;
    next_state.cs2Rd[`TCC_UNIT_MSB:`TCC_UNIT_LSB] = next_state.unitSel;
    next_state.cs2Rd[`TCC_BAI_BIT] = next_state.address_increment_inhibit;
    next_state.cs2Rd[`TCC_PAT_BIT] = next_state.parTest;
    next_state.cs3Rd = 16'h0000;
    next_state.cs3Rd[`TCC_INVERT_BYTE_PARITY_CHECK_MSB:`TCC_INVERT_BYTE_PARITY_CHECK_LSB] = next_state.invert_byte_parity_check;
  end

  // State register, synchronous reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= RESET_ST;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  // No gates after the flops, so no pin can glitch between edges
  assign startInitPulse          = state.initPulse;
  assign busy                    = state.busy;
  assign ready                   = state.ready;
  assign readCmd                 = state.cmd[2];
  assign writeCmd                = state.cmd[1];
  assign writeCheckCmd           = state.cmd[0];
  assign reverseDir              = state.reverse;
  assign functionLoadFlag        = state.fnLoad;
  // RULE_17: unit select drives the select lines
  assign driveSelectLines        = state.unitSel;
  // RULE_20: parity test flips data parity
  // RULE_21: also control-line and buffer-stage parity
  assign parityTestBit           = state.parTest;
  assign addressIncrementInhibit = state.address_increment_inhibit;
  assign programClear            = state.pgClr;
  assign invertByteParityCheck   = state.invert_byte_parity_check;
  assign parityInvert            = state.inv;
  assign cs1ReadData             = state.cs1Rd;
  assign cs2ReadData             = state.cs2Rd;
  assign cs3ReadData             = state.cs3Rd;

  // Checks on the command and control state
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Start acceptance and the pulse it makes
  a_go_starts_init: assert property (accept |=> startInitPulse && busy && !ready) // RULE_03
    else $error("accepted start gave no init pulse");
  a_ready_go_only: assert property (goRequest && !ready && !clearAll // RULE_24
    |=> !startInitPulse && $stable({readCmd, writeCmd, writeCheckCmd}) && (!busy || $past(busy)))
    else $error("start taken while not ready");
  a_init_sets_busy: assert property (startInitPulse |-> busy) // RULE_05
    else $error("init pulse without busy");
  a_init_one_cycle: assert property (startInitPulse |=> !startInitPulse) // RULE_04
    else $error("init pulse longer than one cycle");
  a_fload_after_pulse: assert property (startInitPulse && registerSelect |=> functionLoadFlag) // RULE_06
    else $error("function load not set after init");
  a_fload_drop: assert property (!registerSelect |=> !functionLoadFlag) // RULE_07
    else $error("function load held while deselected");
  a_ready_mirror: assert property (ready == !(readCmd || writeCmd || writeCheckCmd)) // RULE_08
    else $error("ready does not match command flops");
  a_done_clears: assert property (busy && !startInitPulse && endOfSegmentFlag && memoryDone |=> !busy) // RULE_09
    else $error("busy held after completion");
  a_cmd_release: assert property (!busy && !startInitPulse && !registerSelect |=> ready) // RULE_10
    else $error("command flop held while idle");

  // Aborts: each must drop busy by the next edge
  a_gclr_clears: assert property (generalClear |=> !busy && !addressIncrementInhibit) // RULE_11
    else $error("general clear left busy or inhibit");
  a_mxf_clears: assert property (missedTransferError |=> !busy) // RULE_12
    else $error("missed transfer left busy");
  a_ned_clears: assert property (functionLoadFlag && nonexistentDevice |=> !busy) // RULE_13
    else $error("missing drive left busy");

  // Stored control fields and their side effects
  a_inv_gate: assert property (parityInvert == (invertByteParityCheck & {4{!readCmd}})) // RULE_15
    else $error("inversion not gated by read");
  a_unit_load: assert property (storeCs2Lo |=> driveSelectLines == $past(hostData[2:0])) // RULE_18
    else $error("unit select not loaded");
  a_pg_pulse: assert property (pgWrite |=> programClear ##1 !programClear || $past(pgWrite)) // RULE_19
    else $error("program clear pulse wrong");
  a_bai_hold: assert property (!ready && !clearAll |=> $stable(addressIncrementInhibit)) // RULE_22
    else $error("inhibit changed during transfer");

  // Decode checks, written from the code table rather than the decode function
  a_rev_decode: assert property (accept |=> reverseDir == ($past(hostData[2:0]) == 3'h7)) // RULE_02
    else $error("reverse direction decoded wrongly");
  a_cmd_decode: assert property (accept |=> readCmd == ($past(hostData[5:3]) == 3'h7) // RULE_23
    && writeCmd == ($past(hostData[5:3]) == 3'h6) && writeCheckCmd == ($past(hostData[5:3]) == 3'h5))
    else $error("command flop does not match code");
  a_cmd_onehot: assert property ($onehot0({readCmd, writeCmd, writeCheckCmd})) // RULE_23
    else $error("more than one command flop set");
  a_no_start: assert property (storeCs1Lo && (!hostData[0] || hostData[5:3] < 3'h5) |=> !startInitPulse) // RULE_03
    else $error("start without go bit or transfer code");
  a_pulse_from_ready: assert property (startInitPulse |-> $past(ready)) // RULE_04
    else $error("init pulse raised outside ready state");
  a_busy_has_cmd: assert property (busy |-> !ready) // RULE_05
    else $error("busy without a command flop");
  a_fload_keep: assert property (functionLoadFlag && registerSelect |=> functionLoadFlag) // RULE_07
    else $error("function load dropped while selected");
  a_status_word: assert property (cs1ReadData[`TCC_CS1_BUSY_BIT] == busy // RULE_08
    && cs1ReadData[`TCC_CS1_READY_BIT] == ready)
    else $error("first word status bits wrong");
  a_ned_no_start: assert property (functionLoadFlag && nonexistentDevice |=> !startInitPulse) // RULE_13
    else $error("start taken for a missing drive");
  a_invert_byte_parity_check_load: assert property (storeCs3Lo |=> invertByteParityCheck == $past(hostData[3:0])) // RULE_14
    else $error("inversion bits not loaded");
  a_cs3_readback: assert property (cs3ReadData == {12'h000, invertByteParityCheck}) // RULE_14
    else $error("third word readback wrong");
  a_read_no_inv: assert property (readCmd |-> parityInvert == 4'h0) // RULE_15
    else $error("inversion active during read");
  a_unit_lines: assert property (driveSelectLines == cs2ReadData[2:0]) // RULE_17
    else $error("select lines differ from stored unit");
  a_pat_load: assert property (storeCs2Lo |=> parityTestBit == $past(hostData[4])) // RULE_18
    else $error("parity test bit not loaded");
  a_pg_clears: assert property (pgWrite |=> !busy && ready && !addressIncrementInhibit) // RULE_19
    else $error("program clear left state behind");
  a_bai_load: assert property (storeCs2Lo && ready && !clearAll // RULE_22
    |=> addressIncrementInhibit == $past(hostData[3]))
    else $error("inhibit not loaded in ready state");

  // Covers for the main paths
  c_accept: cover property (accept ##1 startInitPulse ##1 functionLoadFlag);
  c_normal_done: cover property (busy ##1 (endOfSegmentFlag && memoryDone) ##1 !busy);
  c_ned_abort: cover property (functionLoadFlag && nonexistentDevice ##1 !busy);
  c_reverse_read: cover property (readCmd && reverseDir);
  c_program_clear: cover property (pgWrite ##1 programClear);

endmodule : tcc_control
`default_nettype wire

//--- rtl/tcc_params.svh
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// First control word fields
`define TCC_GO_BIT          0
`define TCC_LSD_MSB         2
`define TCC_LSD_LSB         0
`define TCC_MSD_MSB         5
`define TCC_MSD_LSB         3
`define TCC_CODE_WCHK       3'h5
`define TCC_CODE_WRITE      3'h6
`define TCC_CODE_READ       3'h7
`define TCC_CODE_REVERSE    3'h7
`define TCC_CS1_READY_BIT   7
`define TCC_CS1_BUSY_BIT    11

// Second control word fields
`define TCC_UNIT_MSB        2
`define TCC_UNIT_LSB        0
`define TCC_BAI_BIT         3
`define TCC_PAT_BIT         4
`define TCC_PGCLR_BIT       5

// Third control word fields
`define TCC_INVERT_BYTE_PARITY_CHECK_MSB        3
`define TCC_INVERT_BYTE_PARITY_CHECK_LSB        0

// Reset values
`define TCC_RST_UNIT        3'h0
`define TCC_RST_INVERT_BYTE_PARITY_CHECK        4'h0
`define TCC_RST_WORD        16'h0000
`define TCC_RST_CS1         16'h0080

`endif

//--- rtl/tcc_pkg.sv
package tcc_pkg;

  // Command phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_INIT = 3'b010,
    PH_RUN  = 3'b100
  } tcc_phase_e;

  // Whole state of the command block
  typedef struct packed {
    tcc_phase_e  phase;
    logic        busy;
    logic        initPulse;
    logic [2:0]  cmd;       // {read, write, writeCheck}
    logic        reverse;
    logic        ready;
    logic        fnLoad;
    logic [2:0]  unitSel;
    logic        parTest;
    logic        address_increment_inhibit;
    logic        pgClr;
    logic [3:0]  invert_byte_parity_check;
    logic [3:0]  inv;
    logic [15:0] cs1Rd;
    logic [15:0] cs2Rd;
    logic [15:0] cs3Rd;
  } tcc_state_s;

endpackage : tcc_pkg
